// [i2c_frame_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module i2c_frame_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [7:0] register_pointer_byte,
    input wire logic       ptr_valid,
    input wire logic [7:0] wr_data,
    input wire logic       wr_valid,
    input wire logic       wr_broadcast,
    input wire logic       rd_req,
    input wire logic       frame_start,
    input wire logic       frame_stop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // user strobes are single-cycle pulses
    ptr_pulse_a: assert property (ptr_valid |=> !ptr_valid) else $error("ptr_valid too long");
    wr_pulse_a: assert property (wr_valid |=> !wr_valid) else $error("wr_valid too long");
    rd_pulse_a: assert property (rd_req |=> !rd_req) else $error("rd_req too long");
    start_pulse_a: assert property (frame_start |=> !frame_start)
        else $error("frame_start too long");
    // no data byte strobe for eight clock cycles after the pointer strobe
    ptr_data_gap_a: assert property (ptr_valid |=> !wr_valid [*8])
        else $error("data byte too soon after pointer");
    // held bytes and the broadcast flag move only with their strobe
    ptr_hold_a: assert property (!$stable(register_pointer_byte) |-> ptr_valid)
        else $error("pointer changed without strobe");
    data_hold_a: assert property (!$stable(wr_data) |-> wr_valid)
        else $error("data changed without strobe");
    bcast_flag_a: assert property (!$stable(wr_broadcast) |-> (ptr_valid || wr_valid))
        else $error("broadcast flag moved alone");
    // device never drives high and is released when the master stops
    open_drain_a: assert property (sda_o == 1'b0) else $error("sda driven high");
    stop_released_a: assert property (frame_stop |-> !sda_oe)
        else $error("sda held at stop");
endmodule : i2c_frame_checker

bind i2c_target_frame_sequencing i2c_frame_checker chk_i (
    .clk(clk), .rstn(rstn), .sda_o(sda_o), .sda_oe(sda_oe),
    .register_pointer_byte(register_pointer_byte), .ptr_valid(ptr_valid),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_broadcast(wr_broadcast),
    .rd_req(rd_req), .frame_start(frame_start), .frame_stop(frame_stop)
);

`default_nettype wire

// [i2c_frame_pkg.sv]
package i2c_frame_pkg;

    // address byte layout: seven address bits above the direction bit
    localparam logic [3:0] ADDR_FIXED_HI   = 4'hE;   // upper nibble of the selectable address
    localparam logic [3:0] BCAST_FIXED_HI  = 4'h0;   // upper nibble of the write-to-all address
    localparam int         ADDR_HI_MSB     = 7;
    localparam int         ADDR_HI_LSB     = 4;
    localparam int         ADDR_SEL_MSB    = 3;
    localparam int         ADDR_SEL_LSB    = 1;
    localparam int         DIR_BIT         = 0;
    localparam logic       DIR_WRITE       = 1'b0;
    localparam logic       DIR_READ        = 1'b1;

    // bit slots within one byte frame on the link
    localparam logic [3:0] BIT_FIRST       = 4'h0;
    localparam logic [3:0] BIT_LAST        = 4'h7;
    localparam logic [3:0] BIT_ACK         = 4'h8;

    // values after reset
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic [2:0] STRAP_RESET     = 3'h0;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_PTR,
        LINK_WDATA,
        LINK_RDATA
    } link_state_t;

endpackage : i2c_frame_pkg

// [i2c_master_model.sv]
`timescale 1ns/10ps
`default_nettype none

// bus master: scl toggles only inside frames and idles high
module i2c_master_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_wire
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // one 48 ns bit slot: data set mid-low, sampled mid-high
    task automatic bit_slot(input logic b, output logic r);
        sda_pull = !b;
        #12 scl = 1'b1;
        #12 r = sda_wire;
        #12 scl = 1'b0;
        #12;
    endtask : bit_slot

    // sda falls with scl high; sda held low past the scl fall for the detector
    task automatic start_cond;
        sda_pull = 1'b1;
        #24 scl = 1'b0;
        #12;
    endtask : start_cond

    task automatic restart_cond;
        sda_pull = 1'b0;
        #12 scl = 1'b1;
        #24 sda_pull = 1'b1;
        #24 scl = 1'b0;
        #12;
    endtask : restart_cond

    task automatic stop_cond;
        sda_pull = 1'b1;
        #12 scl = 1'b1;
        #24 sda_pull = 1'b0;
        #24;
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'b1, r);
        ack = !r;
    endtask : send_byte

    // last byte of a read is answered with not-acknowledge
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(nack, r);
    endtask : recv_byte
endmodule : i2c_master_model

`default_nettype wire

// [i2c_target_frame_sequencing.sv]
// Functional notes
// R1 - read: start, address+write, pointer, repeated start, address+read, then device returns bytes
// R2 - master acknowledges each read byte but the last, then not-acknowledge or stop
// R3 - broadcast address 0000xxx with write accepted regardless of straps, pointer acknowledged
// R4 - broadcast write: every data byte acknowledged including the last, stop closes
// R5 - every transaction begins with a start condition, which restarts the sequence
// R6 - own address is 1110 followed by a selectable three-bit value 0 to 7
// R7 - lower three address bits must equal the three strap pins to respond
// R8 - direction bit zero writes, one reads; broadcast only with direction zero
// R9 - multi-byte data travels most significant byte first, bits msb first
// R10 - not-acknowledge or stop ends the transaction; a new start is needed
// R11 - unmatched address leaves the bus released until the next start
`timescale 1ns/10ps
`default_nettype none

module i2c_target_frame_sequencing (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_clk,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_strap_bit2,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit0,
    output logic [7:0]      register_pointer_byte,
    output logic            ptr_valid,
    output logic [7:0]      wr_data,
    output logic            wr_valid,
    output logic            wr_broadcast,
    output logic            rd_req,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            frame_start,
    output logic            frame_stop
);

    // {own address hit, broadcast hit} for a complete address byte
    function automatic logic [1:0] addr_hit(input logic [7:0] abyte, input logic [2:0] strap);
        logic own;
        logic bc;
        own = (abyte[i2c_frame_pkg::ADDR_HI_MSB:i2c_frame_pkg::ADDR_HI_LSB]
               == i2c_frame_pkg::ADDR_FIXED_HI)                                       // R6
              && (abyte[i2c_frame_pkg::ADDR_SEL_MSB:i2c_frame_pkg::ADDR_SEL_LSB] == strap); // R7
        bc  = (abyte[i2c_frame_pkg::ADDR_HI_MSB:i2c_frame_pkg::ADDR_HI_LSB]
               == i2c_frame_pkg::BCAST_FIXED_HI)
              && (abyte[i2c_frame_pkg::DIR_BIT] == i2c_frame_pkg::DIR_WRITE);          // R3 R8
        return {own, bc};
    endfunction : addr_hit

    // ---------------- system clock side ----------------
    logic [2:0] strap_s1_ff;
    logic [2:0] strap_s2_ff;
    logic [7:0] tx_hold_ff;
    logic       rd_tgl_s1_ff;
    logic       rd_tgl_s2_ff;
    logic       rd_tgl_s3_ff;
    logic       wr_tgl_s1_ff;
    logic       wr_tgl_s2_ff;
    logic       wr_tgl_s3_ff;
    logic       scl_s1_ff;
    logic       scl_s2_ff;
    logic       sda_s1_ff;
    logic       sda_s2_ff;
    logic       sda_s3_ff;
    logic [7:0] reg_ptr_ff;
    logic       ptr_valid_ff;
    logic [7:0] wr_data_ff;
    logic       wr_valid_ff;
    logic       wr_bcast_ff;
    logic       rd_req_ff;
    logic       frame_start_ff;
    logic       frame_stop_ff;
    logic       bus_free_ff;

    // ---------------- link side (scl_clk) ----------------
    i2c_frame_pkg::link_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic [7:0] rx_hold_ff;
    logic       rx_is_ptr_ff;
    logic       rx_bcast_ff;
    logic       bcast_ff;
    logic       sda_hi_ff;
    logic       mack_ff;
    logic       rd_tgl_ff;
    logic       wr_tgl_ff;
    logic       sda_oe_ff;
    logic       sda_o_ff;

    logic [7:0] rx_byte;
    logic [1:0] hit_now;
    logic [1:0] hit_done;
    logic       start_seen;

    // strap pins are static levels; they are resynchronised here and then treated as
    // quasi-static by the link logic, so a strap change during a frame is not supported
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_s1_ff <= i2c_frame_pkg::STRAP_RESET;
            strap_s2_ff <= i2c_frame_pkg::STRAP_RESET;
        end else begin
            strap_s1_ff <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // toggle synchronisers for link events, third stage only for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_tgl_s1_ff <= 1'b0;
            rd_tgl_s2_ff <= 1'b0;
            rd_tgl_s3_ff <= 1'b0;
            wr_tgl_s1_ff <= 1'b0;
            wr_tgl_s2_ff <= 1'b0;
            wr_tgl_s3_ff <= 1'b0;
        end else begin
            rd_tgl_s1_ff <= rd_tgl_ff;
            rd_tgl_s2_ff <= rd_tgl_s1_ff;
            rd_tgl_s3_ff <= rd_tgl_s2_ff;
            wr_tgl_s1_ff <= wr_tgl_ff;
            wr_tgl_s2_ff <= wr_tgl_s1_ff;
            wr_tgl_s3_ff <= wr_tgl_s2_ff;
        end
    end

    // read byte requests; the answer is latched into a word that the link copies later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_req_ff  <= 1'b0;
            tx_hold_ff <= i2c_frame_pkg::BYTE_RESET;
        end else begin
            rd_req_ff <= rd_tgl_s2_ff ^ rd_tgl_s3_ff;
            if (rd_valid) begin
                tx_hold_ff <= rd_data;
            end
        end
    end

    // received bytes: rx_hold is stable for a whole byte time after its toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_ptr_ff   <= i2c_frame_pkg::BYTE_RESET;
            ptr_valid_ff <= 1'b0;
            wr_data_ff   <= i2c_frame_pkg::BYTE_RESET;
            wr_valid_ff  <= 1'b0;
            wr_bcast_ff  <= 1'b0;
        end else begin
            ptr_valid_ff <= 1'b0;
            wr_valid_ff  <= 1'b0;
            if (wr_tgl_s2_ff ^ wr_tgl_s3_ff) begin
                wr_bcast_ff <= rx_bcast_ff;
                if (rx_is_ptr_ff) begin
                    reg_ptr_ff   <= rx_hold_ff;
                    ptr_valid_ff <= 1'b1;
                end else begin
                    wr_data_ff  <= rx_hold_ff;                                       // R9
                    wr_valid_ff <= 1'b1;
                end
            end
        end
    end

    // bus condition monitor; a stop leaves the link clock still, so it is seen here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_s1_ff      <= 1'b1;
            scl_s2_ff      <= 1'b1;
            sda_s1_ff      <= 1'b1;
            sda_s2_ff      <= 1'b1;
            sda_s3_ff      <= 1'b1;
            frame_start_ff <= 1'b0;
            frame_stop_ff  <= 1'b0;
            bus_free_ff    <= 1'b1;
        end else begin
            scl_s1_ff      <= scl_clk;
            scl_s2_ff      <= scl_s1_ff;
            sda_s1_ff      <= sda_i;
            sda_s2_ff      <= sda_s1_ff;
            sda_s3_ff      <= sda_s2_ff;
            frame_start_ff <= scl_s2_ff && sda_s3_ff && !sda_s2_ff;                  // R5
            frame_stop_ff  <= scl_s2_ff && !sda_s3_ff && sda_s2_ff;                  // R10
            // the link clock stands still from a stop to the next start, so the link side
            // never sees sda rise; this level tells it that the bus went free meanwhile
            if (scl_s2_ff && !sda_s3_ff && sda_s2_ff) begin
                bus_free_ff <= 1'b1;                                                 // R5
            end else if (!scl_s2_ff) begin
                bus_free_ff <= 1'b0;
            end
        end
    end

    // ---------------- link logic ----------------
    assign rx_byte    = {rx_sh_ff[6:0], sda_i};
    assign hit_now    = addr_hit(rx_byte, strap_s2_ff);
    assign hit_done   = addr_hit(rx_sh_ff, strap_s2_ff);
    // sda fell while scl was high; bus_free is settled long before the first scl fall
    // after a start and is only cleared once scl is seen low, so it is quasi-static here
    assign start_seen = (sda_hi_ff || bus_free_ff) && !sda_i;                       // R5

    // rising edge: sample data bits msb first, the master acknowledge, and raise events
    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            rx_sh_ff     <= i2c_frame_pkg::BYTE_RESET;
            rx_hold_ff   <= i2c_frame_pkg::BYTE_RESET;
            rx_is_ptr_ff <= 1'b0;
            rx_bcast_ff  <= 1'b0;
            sda_hi_ff    <= 1'b1;
            mack_ff      <= 1'b1;
            rd_tgl_ff    <= 1'b0;
            wr_tgl_ff    <= 1'b0;
        end else begin
            sda_hi_ff <= sda_i;
            if (bit_cnt_ff == i2c_frame_pkg::BIT_ACK) begin
                mack_ff <= sda_i;                                                    // R2
            end else begin
                rx_sh_ff <= rx_byte;                                                 // R9
            end
            // first read byte is fetched as soon as the direction bit is in
            if (state_ff == i2c_frame_pkg::LINK_ADDR && bit_cnt_ff == i2c_frame_pkg::BIT_LAST
                && hit_now[1] && rx_byte[i2c_frame_pkg::DIR_BIT] == i2c_frame_pkg::DIR_READ) begin
                rd_tgl_ff <= !rd_tgl_ff;                                             // R1
            end
            // prefetch the following byte while this one shifts out; costs one spare fetch
            if (state_ff == i2c_frame_pkg::LINK_RDATA && bit_cnt_ff == i2c_frame_pkg::BIT_FIRST) begin
                rd_tgl_ff <= !rd_tgl_ff;                                             // R1
            end
            if ((state_ff == i2c_frame_pkg::LINK_PTR || state_ff == i2c_frame_pkg::LINK_WDATA)
                && bit_cnt_ff == i2c_frame_pkg::BIT_LAST) begin
                rx_hold_ff   <= rx_byte;
                rx_is_ptr_ff <= (state_ff == i2c_frame_pkg::LINK_PTR);
                rx_bcast_ff  <= bcast_ff;
                wr_tgl_ff    <= !wr_tgl_ff;                                          // R4
            end
        end
    end

    // falling edge: sequence the frame and drive sda for acknowledges and read data
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= i2c_frame_pkg::LINK_IDLE;
            bit_cnt_ff <= i2c_frame_pkg::BIT_FIRST;
            tx_sh_ff   <= i2c_frame_pkg::BYTE_RESET;
            bcast_ff   <= 1'b0;
            sda_oe_ff  <= 1'b0;
        end else if (start_seen) begin
            state_ff   <= i2c_frame_pkg::LINK_ADDR;                                  // R5
            bit_cnt_ff <= i2c_frame_pkg::BIT_FIRST;
            sda_oe_ff  <= 1'b0;
        end else begin
            if (bit_cnt_ff == i2c_frame_pkg::BIT_ACK) begin
                bit_cnt_ff <= i2c_frame_pkg::BIT_FIRST;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            unique case (state_ff)
                i2c_frame_pkg::LINK_IDLE: begin
                    sda_oe_ff <= 1'b0;                                               // R11
                end
                i2c_frame_pkg::LINK_ADDR: begin
                    if (bit_cnt_ff == i2c_frame_pkg::BIT_LAST) begin
                        if (hit_done[1] || hit_done[0]) begin
                            sda_oe_ff <= 1'b1;                                       // R3 R7
                            bcast_ff  <= !hit_done[1];
                        end else begin
                            state_ff  <= i2c_frame_pkg::LINK_IDLE;                   // R11
                            sda_oe_ff <= 1'b0;
                        end
                    end else if (bit_cnt_ff == i2c_frame_pkg::BIT_ACK) begin
                        if (rx_sh_ff[i2c_frame_pkg::DIR_BIT] == i2c_frame_pkg::DIR_READ) begin
                            state_ff  <= i2c_frame_pkg::LINK_RDATA;                  // R1 R8
                            tx_sh_ff  <= tx_hold_ff;
                            sda_oe_ff <= !tx_hold_ff[7];
                        end else begin
                            state_ff  <= i2c_frame_pkg::LINK_PTR;                    // R1 R8
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                i2c_frame_pkg::LINK_PTR, i2c_frame_pkg::LINK_WDATA: begin
                    if (bit_cnt_ff == i2c_frame_pkg::BIT_LAST) begin
                        sda_oe_ff <= 1'b1;                                           // R3 R4
                    end else if (bit_cnt_ff == i2c_frame_pkg::BIT_ACK) begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= i2c_frame_pkg::LINK_WDATA;
                    end
                end
                i2c_frame_pkg::LINK_RDATA: begin
                    if (bit_cnt_ff == i2c_frame_pkg::BIT_LAST) begin
                        sda_oe_ff <= 1'b0;  // release for the master acknowledge
                    end else if (bit_cnt_ff == i2c_frame_pkg::BIT_ACK) begin
                        if (!mack_ff) begin
                            tx_sh_ff  <= tx_hold_ff;                                 // R2 R9
                            sda_oe_ff <= !tx_hold_ff[7];
                        end else begin
                            state_ff  <= i2c_frame_pkg::LINK_IDLE;                   // R10
                            sda_oe_ff <= 1'b0;
                        end
                    end else begin
                        tx_sh_ff  <= {tx_sh_ff[6:0], 1'b0};
                        sda_oe_ff <= !tx_sh_ff[6];                                   // R9
                    end
                end
            endcase
        end
    end

    // open drain: the pin value is always low, only the enable moves
    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            sda_o_ff <= 1'b0;
        end else begin
            sda_o_ff <= 1'b0;
        end
    end

    assign sda_o                 = sda_o_ff;
    assign sda_oe                = sda_oe_ff;
    assign register_pointer_byte = reg_ptr_ff;
    assign ptr_valid             = ptr_valid_ff;
    assign wr_data               = wr_data_ff;
    assign wr_valid              = wr_valid_ff;
    assign wr_broadcast          = wr_bcast_ff;
    assign rd_req                = rd_req_ff;
    assign frame_start           = frame_start_ff;
    assign frame_stop            = frame_stop_ff;

endmodule : i2c_target_frame_sequencing

`default_nettype wire

// [i2c_target_frame_sequencing_test.sv]
`timescale 1ns/10ps
`default_nettype none

module i2c_target_frame_sequencing_test;
    logic       clk, rstn, scl_clk, sda_pull, sda_wire, sda_o, sda_oe;
    logic       ptr_valid, wr_valid, wr_broadcast, rd_req, rd_valid, frame_start, frame_stop;
    logic [2:0] strap;
    logic [1:0] rd_idx;
    logic [7:0] register_pointer_byte, wr_data, rd_data, n_ptr, n_wr, d, n_sta, n_sto;
    logic [7:0] rd_bytes [4];
    int         error_cnt, compares;

    assign sda_wire = !(sda_pull | sda_oe); // pull-up; either side may pull low

    i2c_master_model m (.scl(scl_clk), .sda_pull(sda_pull), .sda_wire(sda_wire));

    i2c_target_frame_sequencing dut (
        .clk(clk), .rstn(rstn), .scl_clk(scl_clk), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit0(strap[0]), .register_pointer_byte(register_pointer_byte),
        .ptr_valid(ptr_valid), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_broadcast(wr_broadcast), .rd_req(rd_req), .rd_valid(rd_valid),
        .rd_data(rd_data), .frame_start(frame_start), .frame_stop(frame_stop)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // user side: answer each read request on the next falling edge; count strobes
    always @(negedge clk) begin
        rd_valid <= rd_req;
        if (rd_req) begin
            rd_data <= rd_bytes[rd_idx];
            rd_idx  <= rd_idx + 2'h1;
        end
        if (ptr_valid) n_ptr <= n_ptr + 8'h01;
        if (wr_valid) n_wr <= n_wr + 8'h01;
        if (frame_start) n_sta <= n_sta + 8'h01;
        if (frame_stop) n_sto <= n_sto + 8'h01;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic put(input logic [7:0] b, input logic exp);
        logic a;
        m.send_byte(b, a);
        chk("ack", {7'h00, exp}, {7'h00, a});
    endtask : put

    // straps move well clear of any frame so the sync settles first
    task automatic set_strap(input logic [2:0] s);
        @(negedge clk);
        strap = s;
        repeat (4) @(negedge clk);
        #1; // keep link edges off the system clock edges
    endtask : set_strap

    task automatic own_write;
        for (int s = 0; s < 8; s++) begin
            set_strap(3'(s));
            m.start_cond();
            put({4'hE, 3'(s), 1'b0}, 1'b1);
            m.stop_cond();
        end
        set_strap(3'h5);
        m.start_cond();
        put(8'hEA, 1'b1);
        put(8'h12, 1'b1);
        put(8'hA1, 1'b1);
        put(8'hB2, 1'b1);
        m.stop_cond();
        chk("pointer", 8'h12, register_pointer_byte);
        chk("data", 8'hB2, wr_data);
        chk("bcast", 8'h00, {7'h00, wr_broadcast});
    endtask : own_write

    task automatic broadcast;
        logic [7:0] w0;
        w0 = n_wr;
        m.start_cond();
        put({4'h0, 3'h6, 1'b0}, 1'b1);
        put(8'h34, 1'b1);
        put(8'h01, 1'b1);
        put(8'h02, 1'b1);
        m.stop_cond();
        chk("bcast", 8'h01, {7'h00, wr_broadcast});
        chk("data", 8'h02, wr_data);
        chk("writes", w0 + 8'h02, n_wr);
        m.start_cond();
        put({4'h0, 3'h6, 1'b1}, 1'b0);
        m.stop_cond();
    endtask : broadcast

    // wrong straps stay silent until a fresh start addresses this device
    task automatic foreign;
        logic [7:0] p0;
        logic [7:0] s0;
        logic [7:0] t0;
        p0 = n_ptr;
        s0 = n_sta;
        m.start_cond();
        put(8'hE8, 1'b0);
        t0 = n_sto;
        put(8'h55, 1'b0);
        m.restart_cond();
        put(8'hEA, 1'b1);
        put(8'h66, 1'b1);
        m.stop_cond();
        set_strap(3'h5); // let the stop reach the counters
        chk("pointers", p0 + 8'h01, n_ptr);
        chk("pointer", 8'h66, register_pointer_byte);
        chk("starts", s0 + 8'h02, n_sta);
        chk("stops", t0 + 8'h01, n_sto);
    endtask : foreign

    task automatic read_seq;
        m.start_cond();
        put(8'hEA, 1'b1);
        put(8'h07, 1'b1);
        m.restart_cond();
        rd_idx = 2'h0;
        put(8'hEB, 1'b1);
        m.recv_byte(1'b0, d);
        chk("rd0", 8'hC3, d);
        m.recv_byte(1'b0, d);
        chk("rd1", 8'h5A, d);
        m.recv_byte(1'b1, d);
        chk("rd2", 8'h96, d);
        chk("released", 8'h00, {7'h00, sda_oe});
        m.stop_cond();
        m.start_cond();
        put(8'hEA, 1'b1);
        m.stop_cond();
    endtask : read_seq

    task automatic complete_run;
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end

    initial begin
        rstn     = 1'b0;
        strap    = 3'h5;
        rd_valid = 1'b0;
        rd_data  = 8'h00;
        rd_idx   = 2'h0;
        n_ptr    = 8'h00;
        n_wr     = 8'h00;
        n_sta    = 8'h00;
        n_sto    = 8'h00;
        rd_bytes = '{8'hC3, 8'h5A, 8'h96, 8'h3C};
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        #3;
        own_write();
        broadcast();
        foreign();
        read_seq();
        complete_run();
    end
endmodule : i2c_target_frame_sequencing_test

`default_nettype wire
